//--- design/channel_mode_control.sv
// Purpose: Mode, source and protection control of eight relay channels
// Assumes: Mode and source writes come from the serial logic on this clock;
//          pins and analog detect flags are asynchronous
// Notes:   Every output is a flip-flop
//          Wake delay is a parameter so a bench may shorten it
//
// Notes on behaviour
// - After supply start-up, all eight channel modes load off.
// - Reset pin low forces all registers to defaults, minimum current.
// - All channels in fault-reset enter low-power hold, like a reset.
// - Per-channel source field picks one of four direct control pins.
// - An open direct control pin reads inactive; its channels stay off.
// - Outputs held in fault-reset during reset; off mode on release.
// - No turn-on while the channel clamps; allowed once clamping ends.
// - Output follows serial on/off bits, or selected pin in direct mode.
// - In direct mode pin high acts as on, pin low as off.
// - Device operational within 200 us after reset release; the code takes WAKE_CYCLES + 1 edges, 8001 at 40 MHz.
// - Persistent overload switches channel off and latches overload.
// - After overload, off until fault-reset clears it, then new command.
// - Overheating switches the channel off and latches overtemperature.
// - After overtemperature, off until fault-reset then a fresh on.
// - Only low overload threshold exceeded: long shut-down delay.
// - High overload threshold exceeded: short shut-down delay.
// - Fault-reset channel: output off, no diag currents, flags clear.
// - Serial data output released when chip select high or reset low.
`timescale 1ns/1ps
`default_nettype none
module channel_mode_control
    import relay_ctrl_pkg::*;
#(
    parameter int WAKE_CYCLES = RESET_WAKE_CYCLES // Reset wake delay
) (
    input  wire logic                clock,           // 40 MHz clock
    input  wire logic                rstn,            // Power-on reset, low
    input  wire logic                reset_pin_n,     // Reset pin, low
    input  wire logic                chip_select_n,   // Chip select pin, low
    input  wire logic [SOURCES-1:0]  direct_ctrl_pin, // Pins 1 to 4
    input  wire logic                mode_wr,         // Mode write strobe
    input  wire logic [FIELD_W-1:0]  mode_wr_data,    // Two bits a channel
    input  wire logic                source_wr,       // Source write strobe
    input  wire logic [FIELD_W-1:0]  source_wr_data,  // Two bits a channel
    input  wire logic [CHANNELS-1:0] overload_low,    // Low threshold hit
    input  wire logic [CHANNELS-1:0] overload_high,   // High threshold hit
    input  wire logic [CHANNELS-1:0] overheat,        // Thermal trip level
    input  wire logic [CHANNELS-1:0] clamping,        // Output clamping
    output logic      [CHANNELS-1:0] gate_on,         // Output stage on
    output logic      [CHANNELS-1:0] overload_flag,   // Latched overload
    output logic      [CHANNELS-1:0] overheat_flag,   // Latched overheat
    output logic      [CHANNELS-1:0] diag_current_en, // Diagnosis currents
    output logic      [FIELD_W-1:0]  mode_state,      // Current modes
    output logic      [FIELD_W-1:0]  input_source_select, // Pin choice
    output logic                     low_power_hold,  // Hold state
    output logic                     operational,     // Commands accepted
    output logic                     so_oe_n          // Serial out enable
);

    // Synchronised copies of the asynchronous inputs
    logic                reset_pin_sync;
    logic                chip_select_sync;
    logic [SOURCES-1:0]  pin_sync;
    logic [CHANNELS-1:0] ovl_low_sync;
    logic [CHANNELS-1:0] ovl_high_sync;
    logic [CHANNELS-1:0] overheat_sync;
    logic [CHANNELS-1:0] clamp_sync;

    // Phase and control
    phase_type           phase;
    phase_type           next_phase;
    logic [31:0]         wake_count;
    logic                all_fault_reset;
    logic                in_reset;
    logic [CHANNELS-1:0] want_on;
    logic [CHANNELS-1:0] in_fault_reset;
    logic [CHANNELS-1:0] ovl_expired;
    logic [CHANNELS-1:0] next_gate;
    logic [CHANNELS-1:0] ovl_set;
    logic [CHANNELS-1:0] ot_set;

    // Pin reset idles high, chip select idles high
    pin_synchronizer #(
        .WIDTH       (2),
        .RESET_VALUE (2'h3)
    ) sync_ctrl (
        .clock (clock),
        .rstn  (rstn),
        .async ({reset_pin_n, chip_select_n}),
        .sync  ({reset_pin_sync, chip_select_sync})
    );

    // Direct pins settle low, like the pad pull-down of an open pin
    pin_synchronizer #(
        .WIDTH       (SOURCES),
        .RESET_VALUE (4'h0)
    ) sync_pins (
        .clock (clock),
        .rstn  (rstn),
        .async (direct_ctrl_pin),
        .sync  (pin_sync)
    );

    // Analog detect flags, all four kinds in one group
    pin_synchronizer #(
        .WIDTH       (4 * CHANNELS),
        .RESET_VALUE (32'h0000_0000)
    ) sync_detect (
        .clock (clock),
        .rstn  (rstn),
        .async ({overload_low, overload_high, overheat, clamping}),
        .sync  ({ovl_low_sync, ovl_high_sync, overheat_sync, clamp_sync})
    );

    // Either reset source forces defaults
    // The pin reset acts two edges late, behind its synchroniser
    assign in_reset = !rstn || !reset_pin_sync;

    // Per-channel decode of the mode field
    // Shared by the command decode of all eight channel slices
    function automatic channel_mode_type mode_of(
        input logic [FIELD_W-1:0] field,
        input int                 ch
    );
        mode_of = channel_mode_type'(field[ch*MODE_W +: MODE_W]);
    endfunction : mode_of

    // Per-channel decode of the source field
    function automatic logic selected_pin(
        input logic [FIELD_W-1:0] field,
        input logic [SOURCES-1:0] pins,
        input int                 ch
    );
        selected_pin = pins[field[ch*SRC_W +: SRC_W]];
    endfunction : selected_pin

    // Channel command decode
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_decode
        assign in_fault_reset[ch] =
            (mode_of(mode_state, ch) == MODE_FAULT_RESET);
        // Pin high is an on command, low an off command
        assign want_on[ch] =
            (mode_of(mode_state, ch) == MODE_ON) ||
            ((mode_of(mode_state, ch) == MODE_DIRECT) &&
             selected_pin(input_source_select, pin_sync, ch));
    end

    assign all_fault_reset = &in_fault_reset;

    // Phase sequencing: reset, wake interval, run, low-power hold
    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_RESET: next_phase = PH_WAKE;
            PH_WAKE: begin
                if (wake_count >= 32'(WAKE_CYCLES - 1)) begin
                    next_phase = PH_RUN;
                end
            end
            PH_RUN: begin
                if (all_fault_reset) begin
                    next_phase = PH_HOLD;
                end
            end
            PH_HOLD: begin
                if (!all_fault_reset) begin
                    next_phase = PH_RUN;
                end
            end
            default: next_phase = PH_RESET;
        endcase
    end

    // Phase register
    // Leaving hold is not timed here; the host keeps the standby delay
    always_ff @(posedge clock) begin
        if (in_reset) begin
            phase <= PH_RESET;
        end else begin
            phase <= next_phase;
        end
    end

    // Wake interval counter, only runs in the wake phase
    // Wide enough for any wake parameter without a wrap
    always_ff @(posedge clock) begin
        if (in_reset || phase != PH_WAKE) begin
            wake_count <= '0;
        end else begin
            wake_count <= wake_count + 32'd1;
        end
    end

    // Mode register: fault-reset while in reset, off on release.
    // Writes during the wake interval are dropped, not queued.
    always_ff @(posedge clock) begin
        if (in_reset) begin
            mode_state <= MODE_RESET_ALL;
        end else if (phase == PH_RESET) begin
            mode_state <= MODE_OFF_ALL;
        end else if (mode_wr && (phase == PH_RUN || phase == PH_HOLD)) begin
            mode_state <= mode_wr_data;
        end
    end

    // Source selection: defaults in reset and on entry to hold
    // A write in the hold-entry cycle is lost; the default wins
    always_ff @(posedge clock) begin
        if (in_reset) begin
            input_source_select <= SOURCE_RESET;
        end else if (phase == PH_RUN && next_phase == PH_HOLD) begin
            input_source_select <= SOURCE_RESET;
        end else if (source_wr && (phase == PH_RUN || phase == PH_HOLD)) begin
            input_source_select <= source_wr_data;
        end
    end

    // Overload delay timers, one per channel
    // Timers only run while the stage is on, so an off channel never trips
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_timer
        shutdown_timer timer (
            .clock      (clock),
            .rstn       (!in_reset),
            .active     (gate_on[ch] &&
                         (ovl_low_sync[ch] || ovl_high_sync[ch])),
            .high_level (ovl_high_sync[ch]),
            .expired    (ovl_expired[ch])
        );
    end

    // Fault events: overload after its delay; overheat while on or clamping
    // Overheat while off and not clamping leaves no entry, only blocks
    assign ovl_set = ovl_expired & gate_on;
    assign ot_set  = overheat_sync & (gate_on | clamp_sync);

    // Latched faults: an event in the clearing cycle wins over the clear
    // The pin reset clears them as well, like all registers but so_oe_n and the synchronisers
    always_ff @(posedge clock) begin
        if (in_reset) begin
            overload_flag <= '0;
            overheat_flag <= '0;
        end else begin
            overload_flag <= ovl_set |
                (overload_flag & ~in_fault_reset);
            overheat_flag <= ot_set |
                (overheat_flag & ~in_fault_reset);
        end
    end

    // A latched fault only clears in fault-reset mode, where the command
    // is off, so turning on again always needs a later command.
    assign next_gate = want_on & ~overload_flag & ~overheat_flag &
                       ~ovl_set & ~ot_set & ~overheat_sync &
                       (gate_on | ~clamp_sync) &
                       {CHANNELS{phase == PH_RUN}};

    // Output stages
    always_ff @(posedge clock) begin
        if (in_reset) begin
            gate_on <= '0;
        end else begin
            gate_on <= next_gate;
        end
    end

    // Diagnosis currents only outside fault-reset and hold
    // Wake and hold keep them off to hold the supply current minimal
    always_ff @(posedge clock) begin
        if (in_reset) begin
            diag_current_en <= '0;
        end else if (phase == PH_RUN) begin
            diag_current_en <= ~in_fault_reset;
        end else begin
            diag_current_en <= '0;
        end
    end

    // Status outputs
    always_ff @(posedge clock) begin
        if (in_reset) begin
            low_power_hold <= 1'b0;
            operational    <= 1'b0;
        end else begin
            low_power_hold <= (next_phase == PH_HOLD);
            operational    <= (next_phase == PH_RUN) ||
                              (next_phase == PH_HOLD);
        end
    end

    // Serial output released unless selected and out of reset
    // The pin reset reaches it through the sync chain, not in_reset
    always_ff @(posedge clock) begin
        if (!rstn) begin
            so_oe_n <= 1'b1;
        end else begin
            so_oe_n <= chip_select_sync || !reset_pin_sync;
        end
    end

endmodule : channel_mode_control
`default_nettype wire

//--- design/relay_ctrl_pkg.sv
// Purpose: Shared constants and types of the eight-channel relay control
// Assumes: 40 MHz system clock; mode and source fields two bits per channel
// Notes:   Cycle counts derive from printed times; least times round up
package relay_ctrl_pkg;

    localparam int CHANNELS = 8;
    localparam int SOURCES  = 4;
    localparam int MODE_W   = 2;
    localparam int SRC_W    = 2;
    localparam int FIELD_W  = CHANNELS * MODE_W;
    localparam int CLOCK_MHZ = 40;

    // Channel operating modes as written by the serial command path
    typedef enum logic [1:0] {
        MODE_OFF         = 2'h0,
        MODE_ON          = 2'h1,
        MODE_DIRECT      = 2'h2,
        MODE_FAULT_RESET = 2'h3
    } channel_mode_type;

    // Device phase, one-hot
    typedef enum logic [3:0] {
        PH_RESET = 4'h1,
        PH_WAKE  = 4'h2,
        PH_RUN   = 4'h4,
        PH_HOLD  = 4'h8
    } phase_type;

    // Reset wake delay is a longest time: round down
    localparam int RESET_WAKE_DELAY_US = 200;
    localparam int RESET_WAKE_CYCLES   = RESET_WAKE_DELAY_US * CLOCK_MHZ;

    // Overload shut-down delays are least times: round up
    localparam int OVERLOAD_DELAY_LONG_NS  = 11000;
    localparam int OVERLOAD_DELAY_SHORT_NS = 1500;
    localparam int OVERLOAD_LONG_CYCLES =
        (OVERLOAD_DELAY_LONG_NS * CLOCK_MHZ + 999) / 1000;
    localparam int OVERLOAD_SHORT_CYCLES =
        (OVERLOAD_DELAY_SHORT_NS * CLOCK_MHZ + 999) / 1000;
    localparam int TIMER_W = 10;
    localparam logic [TIMER_W-1:0] LONG_LIMIT =
        TIMER_W'(OVERLOAD_LONG_CYCLES - 1);
    localparam logic [TIMER_W-1:0] SHORT_LIMIT =
        TIMER_W'(OVERLOAD_SHORT_CYCLES - 1);

    // Values after reset
    localparam logic [FIELD_W-1:0] MODE_RESET_ALL = 16'hFFFF;
    localparam logic [FIELD_W-1:0] MODE_OFF_ALL   = 16'h0000;
    localparam logic [FIELD_W-1:0] SOURCE_RESET   = 16'hE4E4;

endpackage : relay_ctrl_pkg

//--- design/pin_synchronizer.sv
// Purpose: Two-stage synchroniser for a group of asynchronous inputs
// Assumes: Single system clock, synchronous active-low reset
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer #(
    parameter int               WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clock, // System clock
    input  wire logic             rstn,  // Synchronous reset, active low
    input  wire logic [WIDTH-1:0] async, // Asynchronous inputs
    output logic      [WIDTH-1:0] sync   // Synchronised copy
);

    logic [WIDTH-1:0] stage_one;

    // Reset to the idle level so nothing is seen before two edges
    always_ff @(posedge clock) begin
        if (!rstn) begin
            stage_one <= RESET_VALUE;
            sync      <= RESET_VALUE;
        end else begin
            stage_one <= async;
            sync      <= stage_one;
        end
    end

endmodule : pin_synchronizer
`default_nettype wire

//--- design/shutdown_timer.sv
// Purpose: Overload shut-down delay of one channel
// Assumes: Detect inputs already synchronised
// Notes:   Restarts from zero whenever the overload condition drops
`timescale 1ns/1ps
`default_nettype none
module shutdown_timer
    import relay_ctrl_pkg::*;
(
    input  wire logic clock,      // System clock
    input  wire logic rstn,       // Synchronous clear, active low
    input  wire logic active,     // Channel on and overload seen
    input  wire logic high_level, // High threshold exceeded
    output logic      expired     // Delay elapsed, level while active
);

    logic [TIMER_W-1:0] count;
    logic [TIMER_W-1:0] limit;

    // High threshold picks the short delay
    assign limit = high_level ? SHORT_LIMIT : LONG_LIMIT;

    // Count while overload persists, restart when it drops
    always_ff @(posedge clock) begin
        if (!rstn || !active) begin
            count <= '0;
        end else if (count != '1) begin
            count <= count + TIMER_W'(1);
        end
    end

    // Registered terminal flag
    always_ff @(posedge clock) begin
        if (!rstn || !active) begin
            expired <= 1'b0;
        end else begin
            expired <= (count >= limit);
        end
    end

endmodule : shutdown_timer
`default_nettype wire

//--- dv/channel_mode_control_chk.sv
// Purpose: Port checks on the relay channel control
// Assumes: Channel 0 stands for all eight in per-channel checks
// Notes:   Pin sync chains add two edges; bounds allow for them
`timescale 1ns/1ps
`default_nettype none
module channel_mode_control_chk
    import relay_ctrl_pkg::*;
#(
    parameter int WAKE_CYCLES = RESET_WAKE_CYCLES // Reset wake delay
) (
    input wire logic                clock,               // System clock
    input wire logic                rstn,                // Reset, low
    input wire logic                chip_select_n,       // Chip select
    input wire logic                mode_wr,             // Mode strobe
    input wire logic [FIELD_W-1:0]  mode_wr_data,        // Mode data
    input wire logic [CHANNELS-1:0] overload_low,        // Low threshold
    input wire logic [CHANNELS-1:0] overload_high,       // High threshold
    input wire logic [CHANNELS-1:0] overheat,            // Thermal trip
    input wire logic [CHANNELS-1:0] clamping,            // Clamping
    input wire logic [CHANNELS-1:0] gate_on,             // Stage on
    input wire logic [CHANNELS-1:0] overload_flag,       // Overload
    input wire logic [CHANNELS-1:0] diag_current_en,     // Diag currents
    input wire logic [FIELD_W-1:0]  mode_state,          // Modes
    input wire logic [FIELD_W-1:0]  input_source_select, // Sources
    input wire logic                low_power_hold,      // Hold
    input wire logic                operational,         // Ready
    input wire logic                so_oe_n              // Serial out enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // Wake interval: silent first, then ready within a bound
    sequence s_wake;
        !operational [*8] ##[1:12] operational;
    endsequence
    // Clamp seen long enough to pass the sync chain
    sequence s_clamped;
        clamping[0] [*4] ##0 !gate_on[0];
    endsequence
    a_reset_defaults: assert property (
        $rose(rstn) |-> mode_state == 16'hFFFF && so_oe_n
        && input_source_select == 16'hE4E4 && gate_on == 8'h00)
        else $error("defaults missing at reset release");
    a_off_after_reset: assert property (
        $rose(rstn) |-> ##[1:4] mode_state == 16'h0000)
        else $error("modes not off after reset");
    a_wake_bounded: assert property (
        $rose(rstn) |-> s_wake)
        else $error("wake interval out of bounds");
    a_mode_write_taken: assert property (
        mode_wr && operational |=> mode_state == $past(mode_wr_data))
        else $error("mode write not taken");
    a_hold_entry: assert property (
        operational && !mode_wr && mode_state == 16'hFFFF |=> low_power_hold)
        else $error("hold not entered");
    a_fault_reset_off: assert property (
        mode_state[1:0] == 2'h3 |=> !gate_on[0] && !diag_current_en[0])
        else $error("fault-reset channel active");
    a_overload_delay: assert property (
        $rose(overload_flag[0]) |-> !gate_on[0]
        && ($past(overload_low[0], 60) || $past(overload_high[0], 60)))
        else $error("overload trip too early or gate left on");
    a_flag_latched: assert property (
        overload_flag[0] && mode_state[1:0] != 2'h3 |=> overload_flag[0])
        else $error("overload flag lost");
    a_overheat_off: assert property (
        overheat[0] [*4] |=> !gate_on[0])
        else $error("gate on while overheated");
    a_clamp_block: assert property (
        s_clamped |=> !gate_on[0])
        else $error("turn-on during clamping");
    a_so_release: assert property (
        chip_select_n [*4] |-> so_oe_n)
        else $error("serial out driven while deselected");
endmodule : channel_mode_control_chk
bind channel_mode_control channel_mode_control_chk #(
    .WAKE_CYCLES(WAKE_CYCLES)
) i_chk (
    .clock(clock), .rstn(rstn), .chip_select_n(chip_select_n),
    .mode_wr(mode_wr), .mode_wr_data(mode_wr_data),
    .overload_low(overload_low), .overload_high(overload_high),
    .overheat(overheat), .clamping(clamping), .gate_on(gate_on),
    .overload_flag(overload_flag), .diag_current_en(diag_current_en),
    .mode_state(mode_state), .input_source_select(input_source_select),
    .low_power_hold(low_power_hold), .operational(operational),
    .so_oe_n(so_oe_n)
);
`default_nettype wire

//--- dv/relay_host_model.sv
// Purpose: Host side of the decoded mode and source writes
// Assumes: Serial framing already turned into one-cycle strobes
// Notes:   Data is inverted after each strobe so stale values never match
`timescale 1ns/1ps
`default_nettype none
module relay_host_model
    import relay_ctrl_pkg::*;
(
    input  wire logic               clock,          // System clock
    output logic                    mode_wr,        // Mode strobe
    output logic      [FIELD_W-1:0] mode_wr_data,   // Mode field
    output logic                    source_wr,      // Source strobe
    output logic      [FIELD_W-1:0] source_wr_data  // Source field
);
    // Idle from time zero
    initial begin
        mode_wr        = 1'b0;
        mode_wr_data   = 16'h0000;
        source_wr      = 1'b0;
        source_wr_data = 16'h0000;
    end
    // One strobe cycle, launched just after an edge
    task automatic write_mode(input logic [FIELD_W-1:0] data);
        @(posedge clock);
        mode_wr      <= 1'b1;
        mode_wr_data <= data;
        @(posedge clock);
        mode_wr      <= 1'b0;
        mode_wr_data <= ~data;
    endtask : write_mode
    task automatic write_source(input logic [FIELD_W-1:0] data);
        @(posedge clock);
        source_wr      <= 1'b1;
        source_wr_data <= data;
        @(posedge clock);
        source_wr      <= 1'b0;
        source_wr_data <= ~data;
    endtask : write_source
endmodule : relay_host_model
`default_nettype wire

//--- dv/octal_channel_mode_protection_test.sv
// Purpose: Self-checking bench of the relay channel control
// Assumes: Wake interval shortened to 10 cycles
// Notes:   Channel 0 carries protection tests, channel 1 direct mode
`timescale 1ns/1ps
`default_nettype none
module octal_channel_mode_protection_test;
    import relay_ctrl_pkg::*;
    logic        clock, rstn, reset_pin_n, chip_select_n;
    logic [3:0]  direct_ctrl_pin;
    logic        mode_wr, source_wr, low_power_hold, operational, so_oe_n;
    logic [15:0] mode_wr_data, source_wr_data, mode_state, src_sel;
    logic [7:0]  overload_low, overload_high, overheat, clamping;
    logic [7:0]  gate_on, overload_flag, overheat_flag, diag_current_en;
    int          errors, checked, n, p;

    channel_mode_control #(.WAKE_CYCLES(10)) i_dut (
        .clock(clock), .rstn(rstn), .reset_pin_n(reset_pin_n),
        .chip_select_n(chip_select_n), .direct_ctrl_pin(direct_ctrl_pin),
        .mode_wr(mode_wr), .mode_wr_data(mode_wr_data),
        .source_wr(source_wr), .source_wr_data(source_wr_data),
        .overload_low(overload_low), .overload_high(overload_high),
        .overheat(overheat), .clamping(clamping), .gate_on(gate_on),
        .overload_flag(overload_flag), .overheat_flag(overheat_flag),
        .diag_current_en(diag_current_en), .mode_state(mode_state),
        .input_source_select(src_sel), .low_power_hold(low_power_hold),
        .operational(operational), .so_oe_n(so_oe_n));
    relay_host_model i_host (
        .clock(clock), .mode_wr(mode_wr), .mode_wr_data(mode_wr_data),
        .source_wr(source_wr), .source_wr_data(source_wr_data));

    // 40 MHz clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic check(input string name, input logic [15:0] exp,
                         input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic tick(input int cycles);
        repeat (cycles) @(posedge clock);
        #1;
    endtask : tick
    task automatic finish_test;
        $display("Errors %0d, checks %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // Bounded wait on a level; running out ends the run
    task automatic wait_for(input int limit, input bit ready);
        n = 0;
        while ((ready ? operational : overload_flag[0]) !== 1'b1
               && n < limit) begin
            tick(1);
            n++;
        end
        if (n >= limit) begin
            errors++;
            finish_test();
        end
    endtask : wait_for
    // Write modes and let the gate follow
    task automatic mode(input logic [15:0] d);
        i_host.write_mode(d);
        tick(2);
    endtask : mode
    // Trip channel 0 on overload, then clear it with fault-reset
    task automatic trip(input logic hi, input int lo_n, input int hi_n);
        @(posedge clock) overload_low <= 8'h01;
        overload_high <= {7'h00, hi};
        wait_for(600, 1'b0);
        check("trip delay", 16'h1,
              16'(n >= lo_n && n <= hi_n));
        check("gate after trip", 16'h0, 16'(gate_on));
        @(posedge clock) overload_low <= 8'h00;
        overload_high <= 8'h00;
        mode(16'h0001);
        check("gate before clear", 16'h0, 16'(gate_on));
        mode(16'h0003);
        check("flag after clear", 16'h0, 16'(overload_flag));
        mode(16'h0001);
        check("gate after clear", 16'h1, 16'(gate_on));
    endtask : trip

    initial begin
        errors = 0;
        checked = 0;
        rstn = 1'b0;
        reset_pin_n = 1'b1;
        chip_select_n = 1'b1;
        direct_ctrl_pin = 4'h0;
        {overload_low, overload_high, overheat, clamping} = 32'h0;
        tick(8);
        check("reset modes", 16'hFFFF, mode_state);
        check("reset sources", 16'hE4E4, src_sel);
        @(posedge clock) rstn <= 1'b1;
        wait_for(100, 1'b1);
        check("modes at start", 16'h0000, mode_state);
        mode(16'hFFFF);
        check("hold", 16'h1, 16'(low_power_hold));
        check("diag currents", 16'h0, 16'(diag_current_en));
        mode(16'h0000);
        check("hold left", 16'h0, 16'(low_power_hold));
        mode(16'h0001);
        check("serial on", 16'h1, 16'(gate_on));
        check("diag on", 16'h00FF, 16'(diag_current_en));
        trip(1'b0, 440, 446);
        trip(1'b1, 60, 66);
        @(posedge clock) overheat <= 8'h01;
        tick(4);
        check("overheat gate", 16'h0, 16'(gate_on));
        check("overheat flag", 16'h1, 16'(overheat_flag));
        @(posedge clock) overheat <= 8'h00;
        mode(16'h0001);
        check("gate before clear", 16'h0, 16'(gate_on));
        mode(16'h0003);
        mode(16'h0001);
        check("gate fresh on", 16'h1, 16'(gate_on));
        mode(16'h0000);
        @(posedge clock) clamping <= 8'h01;
        tick(2);
        mode(16'h0001);
        tick(2);
        check("on while clamping", 16'h0, 16'(gate_on));
        @(posedge clock) clamping <= 8'h00;
        tick(4);
        check("on after clamping", 16'h1, 16'(gate_on));
        // Each pin drives channel 1; the other three stay low or high
        for (p = 0; p < 4; p++) begin
            i_host.write_source(16'hE4E0 | 16'(p << 2));
            mode(16'h0008);
            @(posedge clock) direct_ctrl_pin <= 4'(1 << p);
            tick(4);
            check("pin high", 16'h2, 16'(gate_on));
            @(posedge clock) direct_ctrl_pin <= ~4'(1 << p);
            tick(4);
            check("pin low", 16'h0, 16'(gate_on));
        end
        @(posedge clock) direct_ctrl_pin <= 4'h0;
        tick(4);
        check("open pins", 16'h0, 16'(gate_on));
        @(posedge clock) chip_select_n <= 1'b0;
        tick(4);
        check("serial out driven", 16'h0, 16'(so_oe_n));
        mode(16'h0001);
        check("on before pin reset", 16'h1, 16'(gate_on));
        @(posedge clock) reset_pin_n <= 1'b0;
        tick(50 * CLOCK_MHZ);
        check("pin reset release", 16'h1, 16'(so_oe_n));
        check("pin reset modes", 16'hFFFF, mode_state);
        check("pin reset sources", 16'hE4E4, src_sel);
        check("pin reset gates", 16'h0, 16'(gate_on));
        @(posedge clock) reset_pin_n <= 1'b1;
        wait_for(100, 1'b1);
        check("wake bound", 16'h1, 16'(n <= 16));
        check("modes after pin", 16'h0000, mode_state);
        finish_test();
    end
endmodule : octal_channel_mode_protection_test
`default_nettype wire
